// ### logic/enc_aux_pkg.sv
// Purpose: Shared constants and carrier types for the encoder auxiliary control
// Assumes: 50 MHz reference clock
// Notes: Times are kept in their printed unit; cycle counts derive from them
package enc_aux_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int FILT_US = 1_000;         // Zero-line filter time, 1 ms
    localparam int MIN_PULSE_US = 10_000;   // Least zero pulse, 10 ms
    localparam int PRESET_TO_US = 14_000;   // Timeout after zero signal, 14 ms
    localparam int PRESET_BUSY_US = 15_000; // Processing after preset, 15 ms
    localparam int DIR_RESP_US = 1_000;     // Direction response, 1 ms
    localparam int POWERON_US = 150_000;    // Power-on settle, 150 ms
    localparam int MONOFLOP_NS = 15_000;    // Monoflop, 15 us longest
    localparam longint CYC_PER_MS = CLK_HZ / 1000;
    localparam int FILT_CYC = int'((longint'(FILT_US) * CYC_PER_MS + 999) / 1000);
    localparam int MIN_PULSE_CYC = int'((longint'(MIN_PULSE_US) * CYC_PER_MS + 999) / 1000);
    localparam int PRESET_TO_CYC = int'((longint'(PRESET_TO_US) * CYC_PER_MS + 999) / 1000);
    localparam int PRESET_BUSY_CYC = int'((longint'(PRESET_BUSY_US) * CYC_PER_MS + 999) / 1000);
    localparam int DIR_RESP_CYC = int'((longint'(DIR_RESP_US) * CYC_PER_MS) / 1000);
    localparam int POWERON_CYC = int'((longint'(POWERON_US) * CYC_PER_MS + 999) / 1000);
    localparam int MONOFLOP_CYC = int'((longint'(MONOFLOP_NS) * CYC_PER_MS) / 1_000_000);
    localparam int POS_W = 14;
    localparam logic [POS_W-1:0] PRESET_DEFAULT = 14'h0000;
    localparam int CNT_W = 24;

    // Fault sources gathered together
    typedef struct packed {
        logic sense_err;
        logic light_err;
        logic temp_err;
    } fault_type;

    // Position word and its valid flag toward the serial link
    typedef struct packed {
        logic [POS_W-1:0] pos;
        logic valid;
    } pos_out_type;
endpackage

// ### logic/pin_sync.sv
// Purpose: Three-stage pin synchroniser with agreement of stages two and three
// Assumes: Single clock domain
// Notes: The first stage feeds only the second
`timescale 1ns/1ps
module pin_sync import enc_aux_pkg::*; (
    input wire logic clk,       // Clock
    input wire logic rst_n,     // Synchronised reset
    input wire logic pin,       // Asynchronous pin
    output logic level          // Accepted level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sync_state_type;
    sync_state_type st_r, st_nxt;

    // Shift chain; level moves only when stages two and three agree
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.lvl = st_r.s3;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.lvl;
endmodule // pin_sync

// ### logic/enc_aux_ctrl.sv
// Purpose: Zero-position, direction and status control of an absolute encoder
// Assumes: Power-on reset on rst_n; raw position supplied by the sensing logic
// Notes: Serial framing is outside; this block only holds the monoflop data
//        Direction errors and latched faults clear only on power-on reset
//        Changes on the direction pin during power-on settle are not errors
// Behaviour
// - High zero input loads position as zero
// - Push button triggers the same preset
// - Preset value is a manufacture constant
// - About 1 ms filtering on zero line
// - 14 ms timeout after zero signal
// - 15 ms processing before position valid
// - Status low during post-preset processing
// - Fault-free: LED off, status high
// - Sensing, light, temperature faults pull status
// - Serial mode fault latched until power cycle
// - Clockwise default, direction high counterclockwise
// - Manufacture option inverts direction polarity
// - Direction change acted on within 1 ms
// - Direction change while powered flags error
// - 150 ms power-on before position valid
// - Read within monoflop repeats same data
`timescale 1ns/1ps
module enc_aux_ctrl import enc_aux_pkg::*; #(
    parameter logic [POS_W-1:0] PRESET_VALUE = PRESET_DEFAULT, // Manufacture preset
    parameter bit DIR_INVERT = 1'b0,                           // Manufacture inversion
    parameter int MIN_PULSE = MIN_PULSE_CYC,                   // Least zero pulse cycles
    parameter int PRESET_TO = PRESET_TO_CYC,                   // Zero timeout cycles
    parameter int PRESET_BUSY = PRESET_BUSY_CYC,               // Preset busy cycles
    parameter int POWERON = POWERON_CYC                        // Power-on settle cycles
) (
    input wire logic ref_clk,           // 50 MHz clock
    input wire logic rst_n,             // Power-on reset, active low
    input wire logic zero_pin,          // Zero-position input, active high
    input wire logic zero_button,       // Push button, active high
    input wire logic dir_pin,           // Direction select input
    input wire logic serial_sync_mode,  // High in serial-synchronous mode
    input wire fault_type faults,       // Fault sources, same clock
    input wire logic [POS_W-1:0] raw_pos, // Raw clockwise shaft position
    input wire logic read_start,        // Serial read start pulse
    output pos_out_type pos_out,        // Position held for the read
    output logic status_o,              // Status pin driven level (always low)
    output logic status_oe_n,           // Status enable, low pulls the line low
    output logic led_on,                // Fault LED
    output logic ccw_active,            // Counting counterclockwise
    output logic preset_busy            // Preset in progress
);
    // Direction filter leaves room for the sync stages and the output flop,
    // so the whole path from pin to counting sense stays inside the response time
    localparam int DIR_DLY = (DIR_RESP_CYC > 9) ? DIR_RESP_CYC - 8 : 1;
    // Busy covers the longer of timeout and processing time
    localparam int BUSY_LEN = (PRESET_BUSY > PRESET_TO) ? PRESET_BUSY : PRESET_TO;

    // Refuse counts the counters cannot hold; the hold test needs two cycles
    if (MIN_PULSE < 2 || PRESET_TO < 1 || PRESET_BUSY < 1 || POWERON < 1
        || MIN_PULSE >= (1 << CNT_W) || POWERON >= (1 << CNT_W)
        || BUSY_LEN >= (1 << CNT_W)) begin : g_bad_timing
        $error("enc_aux_ctrl: timing parameters out of range");
    end

    // True once a counter started at zero has spent n cycles
    function automatic logic reached(input logic [CNT_W-1:0] cnt, input int n);
        return cnt >= CNT_W'(n - 1);
    endfunction

    // Counter step, kept at the counter width
    function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] cnt);
        return cnt + 1'b1;
    endfunction

    // Zero request sequence
    typedef enum logic [1:0] {Z_IDLE, Z_HOLD, Z_BUSY, Z_WAIT_LOW} zstate_type;

    // All state in one word so reset and update stay in step
    typedef struct packed {
        logic rs1;
        logic rs2;
        zstate_type zst;
        logic [CNT_W-1:0] zcnt;
        logic [CNT_W-1:0] pcnt;
        logic powered;
        logic [POS_W-1:0] offset;
        logic dir_ref;
        logic ccw;
        logic [CNT_W-1:0] dcnt;
        logic dir_err;
        logic fault_lat;
        logic [CNT_W-1:0] mcnt;
        pos_out_type po;
    } state_type;

    // Registered state and combinational helpers
    state_type st_r, st_nxt;
    logic zero_lvl, btn_lvl, dir_lvl, req;
    logic [POS_W-1:0] dir_pos, cur_pos;
    logic any_fault;

    // Pin synchronisers, held in reset until the internal release
    pin_sync u_zero (.clk(ref_clk), .rst_n(st_r.rs2), .pin(zero_pin), .level(zero_lvl));
    pin_sync u_btn (.clk(ref_clk), .rst_n(st_r.rs2), .pin(zero_button), .level(btn_lvl));
    pin_sync u_dir (.clk(ref_clk), .rst_n(st_r.rs2), .pin(dir_pin), .level(dir_lvl));

    // Request merge and position arithmetic
    assign req = zero_lvl | btn_lvl;
    assign any_fault = faults.sense_err | faults.light_err | faults.temp_err;
    assign dir_pos = st_r.ccw ? POS_W'(~raw_pos + 1'b1) : raw_pos;
    assign cur_pos = POS_W'(dir_pos - st_r.offset);

    // Next state of the whole block
    always_comb begin
        st_nxt = st_r;
        st_nxt.rs1 = 1'b1;
        st_nxt.rs2 = st_r.rs1;
        // Power-on settle
        if (!st_r.powered) begin
            if (reached(st_r.pcnt, POWERON)) begin
                st_nxt.powered = 1'b1;
            end else begin
                st_nxt.pcnt = step(st_r.pcnt);
            end
        end
        // Zero request: filtered, then held for the least pulse time
        case (st_r.zst)
            Z_IDLE: begin
                // Filter time is covered by the hold count
                st_nxt.zcnt = '0;
                if (req) begin
                    st_nxt.zst = Z_HOLD;
                end
            end
            Z_HOLD: begin
                // The idle cycle that saw the request is the first of the pulse
                if (!req) begin
                    st_nxt.zst = Z_IDLE; // Glitch dropped
                end else if (reached(st_r.zcnt, MIN_PULSE - 1)) begin
                    st_nxt.offset = dir_pos - PRESET_VALUE;
                    st_nxt.zcnt = '0;
                    st_nxt.zst = Z_BUSY;
                end else begin
                    st_nxt.zcnt = step(st_r.zcnt);
                end
            end
            Z_BUSY: begin
                if (reached(st_r.zcnt, BUSY_LEN)) begin
                    st_nxt.zst = Z_WAIT_LOW;
                end else begin
                    st_nxt.zcnt = step(st_r.zcnt);
                end
            end
            Z_WAIT_LOW: begin
                // A held level triggers once only
                if (!req) begin
                    st_nxt.zst = Z_IDLE;
                end
            end
            default: st_nxt.zst = Z_IDLE;
        endcase
        // Direction: tracked while settling, later changes are an error.
        // Tracking until settle ends lets a pin that idles high pass the
        // synchronisers without being taken for a change.
        if (!st_r.powered) begin
            st_nxt.dir_ref = dir_lvl;
            st_nxt.ccw = dir_lvl ^ DIR_INVERT;
            st_nxt.dcnt = '0;
        end else if (dir_lvl != st_r.dir_ref) begin
            if (reached(st_r.dcnt, DIR_DLY)) begin
                st_nxt.dir_ref = dir_lvl;
                st_nxt.ccw = dir_lvl ^ DIR_INVERT;
                st_nxt.dir_err = 1'b1;
                st_nxt.dcnt = '0;
            end else begin
                st_nxt.dcnt = step(st_r.dcnt);
            end
        end else begin
            st_nxt.dcnt = '0;
        end
        // Fault latch in serial-synchronous mode, cleared by power only
        // Outside that mode faults follow their sources
        if (serial_sync_mode && any_fault) begin
            st_nxt.fault_lat = 1'b1;
        end
        // Monoflop: a read inside the window repeats the held word
        // Each read restarts the window, so close reads keep one word
        if (st_r.mcnt != '0) begin
            st_nxt.mcnt = st_r.mcnt - 1'b1;
        end
        if (read_start) begin
            st_nxt.mcnt = CNT_W'(MONOFLOP_CYC);
            if (st_r.mcnt == '0) begin
                st_nxt.po.pos = cur_pos;
            end
        end
        // Valid drops on the edge busy rises, so no read in the preset sees it
        st_nxt.po.valid = st_r.powered && (st_nxt.zst != Z_BUSY);
        // All but the release chain waits for the synchronised reset,
        // so counters and pin filters start on the same edge
        if (!st_r.rs2) begin
            st_nxt = '0;
            st_nxt.rs1 = 1'b1;
            st_nxt.rs2 = st_r.rs1;
        end
    end

    // State register; the async reset only clears, never loads data
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Status pin: open drain, low whenever preset busy or any fault.
    // The drive value is fixed low and only the enable moves,
    // so the line never fights the external pull-up.
    assign status_o = 1'b0;
    assign status_oe_n = ~((st_r.zst == Z_BUSY) | any_fault | st_r.fault_lat
        | st_r.dir_err);
    assign led_on = any_fault | st_r.fault_lat | st_r.dir_err;
    assign pos_out = st_r.po;
    assign ccw_active = st_r.ccw;
    assign preset_busy = (st_r.zst == Z_BUSY);
endmodule // enc_aux_ctrl

// ### verif/enc_aux_ctrl_sva.sv
// Purpose: Port checks of encoder auxiliary control
// Assumes: One clock, top ports only
// Notes: Helper counters give zero-run length and read spacing
`timescale 1ns/1ps
module enc_aux_ctrl_sva import enc_aux_pkg::*; #(
    parameter int MIN_PULSE = MIN_PULSE_CYC // Least zero run
) (
    input wire logic ref_clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic zero_pin, // Zero line
    input wire logic zero_button, // Button
    input wire logic dir_pin, // Direction
    input wire logic serial_sync_mode, // Mode
    input wire fault_type faults, // Faults
    input wire logic [POS_W-1:0] raw_pos, // Raw position
    input wire logic read_start, // Read pulse
    input wire pos_out_type pos_out, // Held position
    input wire logic status_o, // Status level
    input wire logic status_oe_n, // Status enable
    input wire logic led_on, // LED
    input wire logic ccw_active, // Direction state
    input wire logic preset_busy // Busy
);
    int run_r;
    int gap_r;
    // Run length survives the drop so a late busy rise is still judged
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_r <= 0;
            gap_r <= 1000;
        end else begin
            run_r <= (zero_pin || zero_button) ? ((run_r > 0 && $past(zero_pin || zero_button))
                ? run_r + 1 : 1) : run_r;
            gap_r <= read_start ? 0 : (gap_r < 1000 ? gap_r + 1 : gap_r);
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_busy_hold; $rose(preset_busy) |-> preset_busy [*8]; endproperty
    property p_oe_busy; preset_busy |-> !status_oe_n; endproperty
    property p_valid_busy; $rose(preset_busy) |-> !pos_out.valid; endproperty
    property p_fault_low; (faults != 3'h0) |-> !status_oe_n; endproperty
    property p_led_low; led_on |-> !status_oe_n; endproperty
    property p_min_pulse; $rose(preset_busy) |-> run_r >= MIN_PULSE; endproperty
    property p_latch; (serial_sync_mode && faults != 3'h0) |=> !status_oe_n [*8]; endproperty
    property p_read_hold; (read_start && gap_r < 700) |=> $stable(pos_out.pos); endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy ended early");
    a_oe_busy: assert property (p_oe_busy) else $error("status high while busy");
    a_valid_busy: assert property (p_valid_busy) else $error("valid during preset");
    a_fault_low: assert property (p_fault_low) else $error("fault not shown");
    a_led_low: assert property (p_led_low) else $error("led without status");
    a_min_pulse: assert property (p_min_pulse) else $error("short zero accepted");
    a_latch: assert property (p_latch) else $error("fault not latched");
    a_read_hold: assert property (p_read_hold) else $error("held read changed");
    c_busy: cover property ($rose(preset_busy));
    c_led: cover property ($rose(led_on));
    c_held: cover property (read_start && gap_r < 700);
endmodule // enc_aux_ctrl_sva

// ### verif/ctrl_model.sv
// Purpose: Controller model driving zero, button and direction lines
// Assumes: Lines change just after a rising edge
// Notes: Zero request is held for a chosen count, then released
`timescale 1ns/1ps
module ctrl_model (
    input wire logic ref_clk, // Clock
    output logic zero_pin, // Zero request
    output logic zero_button, // Panel button
    output logic dir_pin // Direction select
);
    initial begin
        zero_pin = 1'b0;
        zero_button = 1'b0;
        dir_pin = 1'b0;
    end
    // Hold request n cycles; the bench chooses short or legal length
    task automatic hold_zero(input bit btn, input int n);
        @(posedge ref_clk);
        zero_pin <= !btn;
        zero_button <= btn;
        repeat (n) @(posedge ref_clk);
        zero_pin <= 1'b0;
        zero_button <= 1'b0;
    endtask
    // Reverse direction while powered
    task automatic flip_dir();
        @(posedge ref_clk);
        dir_pin <= ~dir_pin;
    endtask
endmodule // ctrl_model

// ### verif/enc_aux_ctrl_tb.sv
// Purpose: Self-checking bench of encoder auxiliary control
// Assumes: Shortened counts through parameters
// Notes: Direction error is sticky, so it runs last
`timescale 1ns/1ps
module enc_aux_ctrl_tb import enc_aux_pkg::*;;
    localparam int MP = 60;
    localparam int BUSY = 30;
    logic ref_clk = 1'b0, rst_n = 1'b0, serial_sync_mode = 1'b0, read_start = 1'b0;
    logic zero_pin, zero_button, dir_pin, status_o, status_oe_n, led_on, ccw_active, preset_busy;
    fault_type faults = 3'h0;
    logic [POS_W-1:0] raw_pos = 14'h0000, exp_pos, off = 14'h0000;
    pos_out_type pos_out;
    logic [31:0] seed = 32'h00014A23;
    int error_cnt = 0, check_count = 0, n;
    always #10 ref_clk = ~ref_clk;
    enc_aux_ctrl #(.MIN_PULSE(MP), .PRESET_TO(20), .PRESET_BUSY(BUSY), .POWERON(50)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .zero_pin(zero_pin), .zero_button(zero_button),
        .dir_pin(dir_pin), .serial_sync_mode(serial_sync_mode), .faults(faults),
        .raw_pos(raw_pos), .read_start(read_start), .pos_out(pos_out), .status_o(status_o),
        .status_oe_n(status_oe_n), .led_on(led_on), .ccw_active(ccw_active),
        .preset_busy(preset_busy));
    ctrl_model u_ctrl (.ref_clk(ref_clk), .zero_pin(zero_pin), .zero_button(zero_button),
        .dir_pin(dir_pin));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Bounded wait on busy (0) or direction (1), counted in negedges
    task automatic wait_sig(input bit which, input logic lvl, input int lim);
        n = 0;
        while ((which ? ccw_active : preset_busy) !== lvl) begin
            @(negedge ref_clk);
            n++;
            if (n > lim) begin
                chk(n, lim);
                conclude();
            end
        end
    endtask
    // Read pulse; result compared with the bench's expected word exp_pos
    task automatic rd();
        @(posedge ref_clk);
        read_start <= 1'b1;
        @(posedge ref_clk);
        read_start <= 1'b0;
        @(negedge ref_clk);
        chk(pos_out.pos, exp_pos);
    endtask
    // Fresh read after monoflop, then a held read with moved shaft
    task automatic fresh(input bit neg);
        repeat (760) @(posedge ref_clk);
        seed = lfsr(seed);
        raw_pos <= seed[13:0];
        exp_pos = seed[13:0];
        if (neg) begin
            exp_pos = -exp_pos;
        end
        exp_pos = exp_pos - off + PRESET_DEFAULT;
        rd();
        @(posedge ref_clk);
        raw_pos <= ~seed[13:0];
        rd();
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (60) @(negedge ref_clk);
        chk({pos_out.valid, status_oe_n, led_on, ccw_active, status_o}, 5'h18);
        fresh(1'b0);
        $display("Power-on and reads done");
        u_ctrl.hold_zero(1'b0, MP - 1);
        repeat (20) @(negedge ref_clk);
        chk(preset_busy, 1'b0);
        for (int s = 0; s < 2; s++) begin
            off = raw_pos;
            fork
                u_ctrl.hold_zero(s[0], MP + 10);
            join_none
            wait_sig(1'b0, 1'b1, MP + 20);
            chk({status_oe_n, pos_out.valid, n >= MP}, 3'h1);
            wait_sig(1'b0, 1'b0, BUSY + 10);
            chk(n, BUSY);
            chk({pos_out.valid, status_oe_n}, 2'h3);
            fresh(1'b0);
        end
        $display("Presets done");
        for (int f = 0; f < 3; f++) begin
            @(posedge ref_clk);
            faults <= fault_type'(3'h1 << f);
            @(negedge ref_clk);
            chk(status_oe_n, 1'b0);
            @(posedge ref_clk);
            faults <= 3'h0;
            @(negedge ref_clk);
            chk(status_oe_n, 1'b1);
        end
        @(posedge ref_clk);
        serial_sync_mode <= 1'b1;
        @(posedge ref_clk);
        faults <= 3'h4;
        @(posedge ref_clk);
        faults <= 3'h0;
        repeat (20) @(negedge ref_clk);
        chk(status_oe_n, 1'b0);
        $display("Faults done");
        // Mid-run reset stands for a power cycle, the only way to clear the latch
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        chk({pos_out.valid, status_oe_n, led_on}, 3'h2);
        repeat (60) @(negedge ref_clk);
        chk({pos_out.valid, status_oe_n, led_on}, 3'h6);
        $display("Power cycle done");
        off = 14'h0000;
        u_ctrl.flip_dir();
        wait_sig(1'b1, 1'b1, DIR_RESP_CYC);
        chk({ccw_active, led_on, status_oe_n}, 3'h6);
        fresh(1'b1);
        $display("Direction done");
        conclude();
    end
endmodule // enc_aux_ctrl_tb
bind enc_aux_ctrl enc_aux_ctrl_sva #(.MIN_PULSE(MIN_PULSE)) u_sva (
    .ref_clk(ref_clk), .rst_n(rst_n), .zero_pin(zero_pin), .zero_button(zero_button),
    .dir_pin(dir_pin), .serial_sync_mode(serial_sync_mode), .faults(faults),
    .raw_pos(raw_pos), .read_start(read_start), .pos_out(pos_out), .status_o(status_o),
    .status_oe_n(status_oe_n), .led_on(led_on), .ccw_active(ccw_active),
    .preset_busy(preset_busy));
